// *** hdl/lrm_pkg.sv ***
// Purpose : constants and carriers for the linear-regulator mask and load meter registers
// Assumes : one clock (mclk, 100 MHz), synchronous active-high reset
// Notes   : register port is a plain address/strobe port from the serial control logic
//
// Summary of operation
// - bit7 masks second regulator pg-invalid event
// - bit6 masks second regulator pg-valid event
// - bit4 masks second regulator overcurrent event
// - bit3 masks first regulator pg-invalid event
// - bit2 masks first regulator pg-valid event
// - bit0 masks first regulator overcurrent event
// - live status ignores all mask bits
// - select bit0 picks step-down, upper bits stored
// - every select write starts a measurement
// - nine-bit result split high bit, low byte
// - 20 mA per count, results read-only
// - measurement done sets flag, mask gates interrupt
package lrm_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] LRM_ADDR_MASK  = 8'h0023;
  localparam logic [7:0] LRM_ADDR_SEL   = 8'h0024;
  localparam logic [7:0] LRM_ADDR_HIGH  = 8'h0025;
  localparam logic [7:0] LRM_ADDR_LOW   = 8'h0026;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int LRM_B_PGF_BIT  = 7;
  localparam int LRM_B_PGR_BIT  = 6;
  localparam int LRM_B_ILIM_BIT = 4;
  localparam int LRM_A_PGF_BIT  = 3;
  localparam int LRM_A_PGR_BIT  = 2;
  localparam int LRM_A_ILIM_BIT = 0;
  localparam logic [7:0] LRM_MASK_WMASK = 8'h00dd;
  localparam logic [7:0] LRM_MASK_RST   = 8'h000c;
  localparam logic [7:0] LRM_SEL_RST    = 8'h0000;
  localparam logic [8:0] LRM_RES_RST    = 9'h0000;
  localparam int LRM_RES_W = 9;
  localparam int LRM_MA_PER_COUNT = 20;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lrm_req_type;

  typedef struct packed {
    logic b_pg;
    logic b_ilim;
    logic a_pg;
    logic a_ilim;
  } lrm_reg_type;

endpackage

// *** hdl/lrm_event_gate.sv ***
// Purpose : turns live regulator conditions into masked flag-set pulses
// Assumes : live inputs already synchronised to mclk
// Notes   : live status passes through untouched
`timescale 1ns/1ps
module lrm_event_gate
  import lrm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // live conditions and mask
  input  wire lrm_pkg::lrm_reg_type live,
  input  wire logic [7:0]           mask,
  // flag-set pulses
  output      lrm_pkg::lrm_reg_type set_pulse
);
  import lrm_pkg::*;

  lrm_reg_type prev_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
      prev_r <= '0;
    else
      prev_r <= live;
  end

  always_comb
  begin
    set_pulse.b_pg   = (prev_r.b_pg & ~live.b_pg & ~mask[LRM_B_PGF_BIT])
                     | (~prev_r.b_pg & live.b_pg & ~mask[LRM_B_PGR_BIT]);
    set_pulse.b_ilim = ~prev_r.b_ilim & live.b_ilim & ~mask[LRM_B_ILIM_BIT];
    set_pulse.a_pg   = (prev_r.a_pg & ~live.a_pg & ~mask[LRM_A_PGF_BIT])
                     | (~prev_r.a_pg & live.a_pg & ~mask[LRM_A_PGR_BIT]);
    set_pulse.a_ilim = ~prev_r.a_ilim & live.a_ilim & ~mask[LRM_A_ILIM_BIT];
  end

  AST_ILIM_A_MASKED: assert property (@(posedge mclk) disable iff (rst)
    mask[LRM_A_ILIM_BIT] |-> !set_pulse.a_ilim) else $error("masked overcurrent set a flag");
  AST_PG_B_FALL: assert property (@(posedge mclk) disable iff (rst)
    ($fell(live.b_pg) && !mask[LRM_B_PGF_BIT]) |-> set_pulse.b_pg) else $error("pg fall lost");
endmodule

// *** hdl/lrm_regs.sv ***
// Purpose : mask register, load meter select/trigger and result registers
// Assumes : live conditions arrive from analog side asynchronously
// Notes   : flags are set here as set pulses; flag registers live elsewhere
`timescale 1ns/1ps
module lrm_regs
  import lrm_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst,
  // register port from serial control
  input  wire lrm_pkg::lrm_req_type     req,
  output      logic [7:0]               rdata,
  // live regulator conditions, asynchronous
  input  wire lrm_pkg::lrm_reg_type     live_async,
  // flag-set pulses and live status
  output      lrm_pkg::lrm_reg_type     flag_set,
  output      lrm_pkg::lrm_reg_type     status_live,
  // measuring circuit
  output      logic                     meter_start,
  output      logic                     meter_step_down_sel,
  input  wire logic                     meter_done,
  input  wire logic [8:0]               meter_value,
  // measurement-ready flag towards top-level register
  input  wire logic                     meter_done_mask,
  output      logic                     meter_done_flag_set,
  output      logic                     meter_irq_req
);
  import lrm_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  lrm_reg_type     sync1_r;
  lrm_reg_type     sync2_r;
  lrm_reg_type     set_nxt;
  logic [7:0]      mask_r;
  logic [7:0]      sel_r;
  logic [8:0]      result_r;
  logic            busy_r;

  function automatic logic hit(input lrm_req_type r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // two-flop synchroniser for live conditions
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= live_async;
      sync2_r <= sync1_r;
    end
  end

  // live status unmasked
  always_ff @(posedge mclk)
  begin
    if (rst)
      status_live <= '0;
    else
      status_live <= sync2_r;
  end

  lrm_event_gate u_gate
  (
    .mclk      (mclk),
    .rst       (rst),
    .live      (sync2_r),
    .mask      (mask_r),
    .set_pulse (set_nxt)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
      flag_set <= '0;
    else
      flag_set <= set_nxt;
  end

  // ---------------------------------------------------------------
  // mask register
  // ---------------------------------------------------------------
  // reserved bits 5 and 1 stay zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      mask_r <= LRM_MASK_RST;
    else if (hit(req, LRM_ADDR_MASK))
      mask_r <= req.wdata & LRM_MASK_WMASK;
  end

  // ---------------------------------------------------------------
  // load meter select and trigger
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      sel_r <= LRM_SEL_RST;
    else if (hit(req, LRM_ADDR_SEL))
      sel_r <= req.wdata;
  end

  // any select write retriggers, even same selection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meter_start         <= 1'b0;
      meter_step_down_sel <= 1'b0;
    end
    else
    begin
      meter_start <= hit(req, LRM_ADDR_SEL);
      if (hit(req, LRM_ADDR_SEL))
        meter_step_down_sel <= req.wdata[0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      busy_r <= 1'b0;
    else if (meter_start)
      busy_r <= 1'b1;
    else if (meter_done)
      busy_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // result and completion
  // ---------------------------------------------------------------
  // both halves load in one edge so a split read never tears mid-update
  always_ff @(posedge mclk)
  begin
    if (rst)
      result_r <= LRM_RES_RST;
    else if (meter_done && busy_r)
      result_r <= meter_value;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      meter_done_flag_set <= 1'b0;
      meter_irq_req       <= 1'b0;
    end
    else
    begin
      meter_done_flag_set <= meter_done && busy_r;
      meter_irq_req       <= meter_done && busy_r && !meter_done_mask;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // results read-only; 20 mA per count, writes ignored
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 8'h0000;
    else if (req.rd)
    begin
      case (req.addr)
        LRM_ADDR_MASK: rdata <= mask_r;
        LRM_ADDR_SEL:  rdata <= sel_r;
        LRM_ADDR_HIGH: rdata <= {7'h0000, result_r[8]};
        LRM_ADDR_LOW:  rdata <= result_r[7:0];
        default:       rdata <= 8'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_MASK_RESET: assert property (@(posedge mclk)
    $fell(rst) |-> mask_r == LRM_MASK_RST) else $error("mask reset wrong");
  AST_B_RESET: assert property (@(posedge mclk)
    $fell(rst) |-> mask_r[7:6] == 2'h0 && !mask_r[4]) else $error("second mask reset wrong");
  AST_START: assert property (@(posedge mclk) disable iff (rst)
    hit(req, LRM_ADDR_SEL) |=> meter_start && meter_step_down_sel == $past(req.wdata[0]))
    else $error("select write did not start");
  AST_SEL_STORE: assert property (@(posedge mclk) disable iff (rst)
    hit(req, LRM_ADDR_SEL) |=> sel_r == $past(req.wdata)) else $error("select not stored");
  AST_RES_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !$past(meter_done) |-> $stable(result_r)) else $error("result changed without done");
  AST_HIGH_READ: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr == LRM_ADDR_HIGH) |=> rdata == {7'h0000, $past(result_r[8])})
    else $error("high result read wrong");
  AST_IRQ_MASK: assert property (@(posedge mclk) disable iff (rst)
    meter_irq_req |-> meter_done_flag_set && !$past(meter_done_mask)) else $error("irq despite mask");
  AST_IRQ_SET: assert property (@(posedge mclk) disable iff (rst)
    (meter_done && busy_r && !meter_done_mask) |=> meter_irq_req) else $error("unmasked done gave no irq");
  AST_DONE_FLAG: assert property (@(posedge mclk) disable iff (rst)
    (meter_done && busy_r) |=> meter_done_flag_set) else $error("done did not set flag");
  // selection only moves on a write, so a stray strobe cannot switch converters
  AST_SEL_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !$past(req.wr) |-> $stable(meter_step_down_sel)) else $error("selection changed without write");
  AST_LIVE: assert property (@(posedge mclk) disable iff (rst)
    status_live == $past(sync2_r)) else $error("live status lost");
  AST_RO: assert property (@(posedge mclk) disable iff (rst)
    (hit(req, LRM_ADDR_LOW) && !$past(meter_done)) |=> $stable(result_r)) else $error("result written");

  COV_TRIGGER: cover property (@(posedge mclk) hit(req, LRM_ADDR_SEL) ##[1:50] meter_done_flag_set);
  COV_RETRIGGER: cover property (@(posedge mclk) hit(req, LRM_ADDR_SEL) ##1 hit(req, LRM_ADDR_SEL));
  COV_PG_SET: cover property (@(posedge mclk) flag_set.b_pg);
  COV_MASKED_DONE: cover property (@(posedge mclk) meter_done_flag_set && !meter_irq_req);
endmodule

// *** verif/lrm_meter_model.sv ***
// Purpose : stand-in for the load meter that answers each start pulse
// Assumes : one start at a time, answer after DLY cycles
// Notes   : result bus shows inverted data outside the done pulse
`timescale 1ns/1ps
module lrm_meter_model
#(
  parameter int DLY = 4
)
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // trigger and answer
  input  wire logic       start,
  input  wire logic [8:0] val,
  output      logic       done,
  output      logic [8:0] value
);
  int cnt_r;

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_r <= 0;
    else if (start)
      cnt_r <= DLY;
    else if (cnt_r != 0)
      cnt_r <= cnt_r - 1;
  end

  assign done  = (cnt_r == 1);
  // stale data is never left on the bus, so a late sample cannot pass by luck
  assign value = done ? val : ~val;
endmodule

// *** verif/linreg_mask_and_load_meter_regs_tb_top.sv ***
// Purpose : self-checking bench for lrm_regs
// Assumes : lrm_meter_model answers each measurement start
// Notes   : all inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module linreg_mask_and_load_meter_regs_tb_top;
  import lrm_pkg::*;
  logic        mclk  = 1'b0;
  logic        rst   = 1'b1;
  lrm_req_type req   = '0;
  logic [3:0]  live  = 4'h0;
  logic        dmask = 1'b0;
  logic [8:0]  tval  = 9'h0000;
  logic [7:0]  rdata;
  logic [3:0]  flag_set;
  logic [3:0]  status_live;
  logic        mstart, msel, mdone, dflag, dirq;
  logic [8:0]  mval;
  int          n_errors  = 0;
  int          tests_run = 0;

  always #5 mclk = ~mclk;

  lrm_regs i_dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .live_async(live), .flag_set(flag_set),
    .status_live(status_live), .meter_start(mstart), .meter_step_down_sel(msel), .meter_done(mdone),
    .meter_value(mval), .meter_done_mask(dmask), .meter_done_flag_set(dflag), .meter_irq_req(dirq));
  lrm_meter_model i_meter (.mclk(mclk), .rst(rst), .start(mstart), .val(tval), .done(mdone), .value(mval));

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h0000};
    @(negedge mclk);
    req.rd = 1'b0;
    @(negedge mclk);
    `CHK("rdata", e, rdata)
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rc(LRM_ADDR_MASK, 8'h000c);
    rc(LRM_ADDR_SEL, 8'h0000);
    rc(LRM_ADDR_HIGH, 8'h0000);
  endtask

  task automatic t_mask();
    wr(LRM_ADDR_MASK, 8'h00ff);
    rc(LRM_ADDR_MASK, 8'h00dd);
    wr(LRM_ADDR_MASK, 8'h0000);
    rc(LRM_ADDR_MASK, 8'h0000);
  endtask

  task automatic ev(input logic [7:0] m, input logic [3:0] lv, input int b, input int n);
    int cnt;
    int oth;
    cnt = 0;
    oth = 0;
    wr(LRM_ADDR_MASK, m);
    live = lv;
    repeat (10)
    begin
      @(negedge mclk);
      cnt += int'(flag_set[b] === 1'b1);
      oth += int'((flag_set & ~(4'h1 << b)) !== 4'h0);
    end
    `CHK("flag_pulses", n, cnt)
    `CHK("other_flags", 0, oth)
    `CHK("status_live", lv, status_live)
  endtask

  task automatic t_events();
    ev(8'h0000, 4'h1, 0, 1);
    ev(8'h0001, 4'h0, 0, 0);
    ev(8'h0001, 4'h1, 0, 0);
    ev(8'h0004, 4'h2, 1, 0);
    ev(8'h0004, 4'h0, 1, 1);
    ev(8'h0008, 4'h2, 1, 1);
    ev(8'h0008, 4'h0, 1, 0);
    ev(8'h0040, 4'h8, 3, 0);
    ev(8'h0040, 4'h0, 3, 1);
    ev(8'h0080, 4'h8, 3, 1);
    ev(8'h0080, 4'h0, 3, 0);
    ev(8'h0010, 4'h4, 2, 0);
    ev(8'h0000, 4'h0, 2, 0);
    ev(8'h0000, 4'h4, 2, 1);
  endtask

  task automatic mt(input logic [7:0] s, input logic [8:0] v, input logic mk);
    int ns, nf, ni;
    ns = 0;
    nf = 0;
    ni = 0;
    tval = v;
    dmask = mk;
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: LRM_ADDR_SEL, wdata: s};
    for (int i = 0; i < 16; i++)
    begin
      @(negedge mclk);
      req.wr = 1'b0;
      ns += int'(mstart === 1'b1);
      nf += int'(dflag === 1'b1);
      ni += int'(dirq === 1'b1);
    end
    `CHK("starts", 1, ns)
    `CHK("step_down_sel", s[0], msel)
    `CHK("done_flags", 1, nf)
    `CHK("irq_reqs", mk ? 0 : 1, ni)
    rc(LRM_ADDR_SEL, s);
    rc(LRM_ADDR_HIGH, {7'h0000, v[8]});
    rc(LRM_ADDR_LOW, v[7:0]);
    rc(LRM_ADDR_LOW, v[7:0]);
  endtask

  task automatic t_ro();
    wr(LRM_ADDR_HIGH, 8'h00fe);
    wr(LRM_ADDR_LOW, 8'h0011);
    rc(LRM_ADDR_HIGH, 8'h0000);
    rc(LRM_ADDR_LOW, 8'h00aa);
    rc(8'h0030, 8'h0000);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_mask();
    t_events();
    mt(8'h0001, 9'h01ff, 1'b0);
    mt(8'h00fe, 9'h0155, 1'b1);
    mt(8'h00fe, 9'h00aa, 1'b0);
    t_ro();
    close_out();
  end
endmodule
